// ---- src/loop_ctl_pkg.sv ----
// shared constants for the modem loopback and DTE control block
package loop_ctl_pkg;

	// avalon-mm register map, byte addresses
	localparam int          BUS_ADDR_W      = 4;
	localparam int          BUS_DATA_W      = 32;
	localparam int          BUS_BE_W        = 4;
	localparam logic [3:0]  ADDR_CTRL       = 4'h0;
	localparam logic [3:0]  ADDR_STATUS     = 4'h4;
	localparam logic [3:0]  ADDR_CTS_DELAY  = 4'h8;

	// control register fields
	localparam int          CTRL_W          = 3;
	localparam int          CTRL_FAR_BIT    = 0;
	localparam int          CTRL_DATA_BIT   = 1;
	localparam int          CTRL_ANALOG_BIT = 2;
	localparam logic [2:0]  CTRL_RESET      = 3'h0;

	// status register fields
	localparam int          STAT_MODE_LSB   = 0;
	localparam int          STAT_CTS_BIT    = 4;
	localparam int          STAT_DSR_BIT    = 5;
	localparam int          STAT_DCD_BIT    = 6;
	localparam int          STAT_TEST_BIT   = 7;
	localparam int          STAT_RTS_BIT    = 8;
	localparam int          STAT_LOSS_BIT   = 9;
	localparam int          STAT_FARCMD_BIT = 10;

	// request-to-send to clear-to-send delay
	localparam int          CLK_FREQ_MHZ     = 125;
	localparam int          CTS_DELAY_NS     = 8000;
	localparam int          CTS_DELAY_CYCLES = (CTS_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int          CTS_CNT_W        = 16;

	// synchroniser widths and line idle level
	localparam int          SYS_SYNC_W      = 7;
	localparam int          LINK_SYNC_W     = 6;
	localparam logic        LINE_MARK       = 1'b1;

	// loopback modes, at most one at a time
	typedef enum logic [2:0] {
		MODE_IDLE       = 3'b000,
		MODE_ANALOG     = 3'b001,
		MODE_FAR_REQ    = 3'b010,
		MODE_DATA_LOOP  = 3'b011,
		MODE_FAR_LOOPED = 3'b100
	} loop_mode_e;

endpackage

// ---- src/sync_bit.sv ----
// two flip-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module sync_bit #(
	parameter int WIDTH = 1 // number of independent levels
)(
	input  wire logic             clk,    // destination clock
	input  wire logic             resetn, // async reset, active low
	input  wire logic [WIDTH-1:0] d,      // asynchronous levels
	output logic      [WIDTH-1:0] q       // synchronised levels
);
	logic [WIDTH-1:0] meta_r;

	if (WIDTH < 1) begin : g_bad_width
		$error("sync_bit width must be at least one");
	end

	// each bit is its own level, so no bus skew concerns
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				meta_r[i] <= 1'b0;
				q[i]      <= 1'b0;
			end else begin
				meta_r[i] <= d[i];
				q[i]      <= meta_r[i];
			end
		end
	end
endmodule

// ---- src/link_datapath.sv ----
// link-clock side of the modem: data routing for the loopbacks and data-rate clocks
`timescale 1ns/1ps
module link_datapath
	import loop_ctl_pkg::*;
(
	input  wire logic linkClk,        // recovered data-rate clock of the optical line
	input  wire logic resetn,         // async reset, active low
	input  wire logic analogLoop,     // local analog loop level, system domain
	input  wire logic dataLoop,       // local data loop level, system domain
	input  wire logic sendLoopCmd,    // far loop command level, system domain
	input  wire logic dteTxData,      // serial data from the DTE
	input  wire logic lineRxData,     // serial data from the optical receiver
	input  wire logic lineLoopCmdIn,  // loop command flag decoded from the line
	output logic      lineTxData,     // serial data to the optical transmitter
	output logic      lineLoopCmdOut, // loop command flag toward the far modem
	output logic      dteRxData,      // serial data to the DTE
	output logic      farCmdSeen,     // far modem asks us to loop, link domain level
	output logic      txClkOut,       // data-rate transmit clock to the DTE
	output logic      rxClkOut        // data-rate receive clock to the DTE
);
	logic [LINK_SYNC_W-1:0] linkRaw;
	logic [LINK_SYNC_W-1:0] linkSync;

	// every input passes two flops on the link clock
	assign linkRaw = {lineLoopCmdIn, lineRxData, dteTxData, sendLoopCmd, dataLoop, analogLoop};

	sync_bit #(.WIDTH(LINK_SYNC_W)) u_link_sync (
		.clk    (linkClk),
		.resetn (resetn),
		.d      (linkRaw),
		.q      (linkSync)
	);

	// data-rate clocks: data outputs below change on the rising edge of these
	assign txClkOut = linkClk;
	assign rxClkOut = linkClk;

	// line transmitter: mark in analog loop, received data in data loop
	always_ff @(posedge linkClk or negedge resetn) begin
		if (!resetn) begin
			lineTxData <= LINE_MARK;
		end else if (linkSync[0]) begin
			lineTxData <= LINE_MARK;
		end else if (linkSync[1]) begin
			lineTxData <= linkSync[4];
		end else begin
			lineTxData <= linkSync[3];
		end
	end

	// received data toward the DTE, own transmit data in analog loop
	always_ff @(posedge linkClk or negedge resetn) begin
		if (!resetn) begin
			dteRxData <= LINE_MARK;
		end else begin
			dteRxData <= linkSync[0] ? linkSync[3] : linkSync[4];
		end
	end

	// loop command in both directions
	always_ff @(posedge linkClk or negedge resetn) begin
		if (!resetn) begin
			lineLoopCmdOut <= 1'b0;
			farCmdSeen     <= 1'b0;
		end else begin
			lineLoopCmdOut <= linkSync[2];
			farCmdSeen     <= linkSync[5];
		end
	end
endmodule

// ---- src/modem_loopback_dte_control.sv ----
// loopback mode control, DTE handshake signals and register slave of the optical modem
`timescale 1ns/1ps
// Notes on behaviour
// - far-loop button makes the device command the far modem to loop data back
// - test indicator lights while we request or are held in a far loop
// - remote loop request pin also starts the far loop, like the button
// - local data loop button retransmits line receive data back to the far modem
// - received data toward the DTE changes on the rising accompanying clock edge
// - clear-to-send follows request-to-send after a delay, only when ready
// - data-set-ready is on unless in data loop or looped by the far modem
// - carrier-detect is on unless signal loss or data-set-ready is off
// - device drives a data-rate transmit clock for the DTE
// - device drives a data-rate receive clock aligned with receive data
// - local loop request input puts the device in local analog loop
// - remote loop request input sends the far loop command
// - test indicator is on in any loop mode and off otherwise
// - analog loop returns transmit data locally and holds the line at mark
module modem_loopback_dte_control #(
	parameter int CTS_DELAY_RESET = loop_ctl_pkg::CTS_DELAY_CYCLES // reset value of the cts delay
)(
	input  wire logic                                 clk,                 // system clock, 125 MHz
	input  wire logic                                 resetn,              // async reset, active low
	input  wire logic [loop_ctl_pkg::BUS_ADDR_W-1:0]  avsAddress,          // register byte address
	input  wire logic                                 avsRead,             // read request
	input  wire logic                                 avsWrite,            // write request
	input  wire logic [loop_ctl_pkg::BUS_DATA_W-1:0]  avsWriteData,        // write data
	input  wire logic [loop_ctl_pkg::BUS_BE_W-1:0]    avsByteEnable,       // write byte lanes
	output logic      [loop_ctl_pkg::BUS_DATA_W-1:0]  avsReadData,         // read data
	output logic                                      avsWaitRequest,      // stall the master
	input  wire logic                                 farLoopButton,       // front panel far loop button
	input  wire logic                                 localDataLoopButton, // front panel local data loop
	input  wire logic                                 localLoopRequest,    // DTE pin, local analog loop
	input  wire logic                                 remoteLoopRequest,   // DTE pin, far loop request
	input  wire logic                                 rtsIn,               // DTE request to send
	input  wire logic                                 lineSignalLoss,      // optical receive signal lost
	output logic                                      ctsOut,              // clear to send
	output logic                                      dsrOut,              // data set ready
	output logic                                      dcdOut,              // carrier detect
	output logic                                      testModeIndicator,   // test indicator
	input  wire logic                                 linkClk,             // optical line data-rate clock
	input  wire logic                                 dteTxData,           // serial data from the DTE
	input  wire logic                                 lineRxData,          // serial data from the line
	input  wire logic                                 lineLoopCmdIn,       // loop command from far modem
	output logic                                      lineTxData,          // serial data to the line
	output logic                                      lineLoopCmdOut,      // loop command to far modem
	output logic                                      dteRxData,           // serial data to the DTE
	output logic                                      txClkOut,            // transmit clock to the DTE
	output logic                                      rxClkOut             // receive clock to the DTE
);
	import loop_ctl_pkg::*;

	if (CTS_DELAY_RESET < 0 || CTS_DELAY_RESET >= (1 << CTS_CNT_W)) begin : g_bad_delay
		$error("cts delay does not fit the delay counter");
	end

	logic [SYS_SYNC_W-1:0] sysRaw;
	logic [SYS_SYNC_W-1:0] sysSync;
	logic                  farBtnS;
	logic                  dataBtnS;
	logic                  localReqS;
	logic                  remoteReqS;
	logic                  rtsS;
	logic                  lossS;
	logic                  farCmdS;
	logic                  farCmdLink;
	logic [CTRL_W-1:0]     ctrl_r;
	logic [CTS_CNT_W-1:0]  ctsDelay_r;
	logic [CTS_CNT_W-1:0]  ctsCnt_r;
	logic                  ack_r;
	logic                  busWriteFire;
	logic                  analogWant;
	logic                  farWant;
	logic                  dataWant;
	logic                  ready;
	logic                  dsrNxt;
	logic                  analogLoop_r;
	logic                  dataLoop_r;
	logic                  sendCmd_r;
	loop_mode_e            mode_r;
	loop_mode_e            mode_nxt;

	// status word built from the live state of the block
	function automatic logic [BUS_DATA_W-1:0] status_word(
		input loop_mode_e mode,
		input logic       cts,
		input logic       dsr,
		input logic       dcd,
		input logic       tst,
		input logic       rts,
		input logic       loss,
		input logic       fcmd
	);
		logic [BUS_DATA_W-1:0] w;
		w                      = '0;
		w[STAT_MODE_LSB +: 3]  = mode;
		w[STAT_CTS_BIT]        = cts;
		w[STAT_DSR_BIT]        = dsr;
		w[STAT_DCD_BIT]        = dcd;
		w[STAT_TEST_BIT]       = tst;
		w[STAT_RTS_BIT]        = rts;
		w[STAT_LOSS_BIT]       = loss;
		w[STAT_FARCMD_BIT]     = fcmd;
		return w;
	endfunction

	// pins and the link-domain command level pass two flops
	assign sysRaw = {farCmdLink, lineSignalLoss, rtsIn, remoteLoopRequest,
	                 localLoopRequest, localDataLoopButton, farLoopButton};

	sync_bit #(.WIDTH(SYS_SYNC_W)) u_sys_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      (sysRaw),
		.q      (sysSync)
	);

	assign farBtnS    = sysSync[0];
	assign dataBtnS   = sysSync[1];
	assign localReqS  = sysSync[2];
	assign remoteReqS = sysSync[3];
	assign rtsS       = sysSync[4];
	assign lossS      = sysSync[5];
	assign farCmdS    = sysSync[6];

	// bus handshake: every access takes exactly one wait cycle
	assign avsWaitRequest = (avsRead | avsWrite) & ~ack_r;
	assign busWriteFire   = avsWrite & ack_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avsRead | avsWrite) & ~ack_r;
		end
	end

	// register writes, honouring byte lanes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r     <= CTRL_RESET;
			ctsDelay_r <= CTS_CNT_W'(CTS_DELAY_RESET);
		end else if (busWriteFire) begin
			if (avsAddress == ADDR_CTRL && avsByteEnable[0]) begin
				ctrl_r <= avsWriteData[CTRL_W-1:0];
			end
			if (avsAddress == ADDR_CTS_DELAY) begin
				if (avsByteEnable[0]) begin
					ctsDelay_r[7:0] <= avsWriteData[7:0];
				end
				if (avsByteEnable[1]) begin
					ctsDelay_r[15:8] <= avsWriteData[15:8];
				end
			end
		end
	end

	// read data captured in the wait cycle, stands at the accepting edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avsReadData <= '0;
		end else if (avsRead && !ack_r) begin
			case (avsAddress)
				ADDR_CTRL: begin
					avsReadData <= {{(BUS_DATA_W-CTRL_W){1'b0}}, ctrl_r};
				end
				ADDR_STATUS: begin
					avsReadData <= status_word(mode_r, ctsOut, dsrOut, dcdOut, testModeIndicator,
					                           rtsS, lossS, farCmdS);
				end
				ADDR_CTS_DELAY: begin
					avsReadData <= {{(BUS_DATA_W-CTS_CNT_W){1'b0}}, ctsDelay_r};
				end
				default: begin
					avsReadData <= '0;
				end
			endcase
		end
	end

	// loop requests from panel, DTE pins and software
	assign analogWant = localReqS | ctrl_r[CTRL_ANALOG_BIT];
	assign farWant    = farBtnS | remoteReqS | ctrl_r[CTRL_FAR_BIT];
	assign dataWant   = dataBtnS | ctrl_r[CTRL_DATA_BIT];

	// mode selection; a mode holds until its own request drops
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			MODE_IDLE: begin
				if (farCmdS) begin
					mode_nxt = MODE_FAR_LOOPED;
				end else if (analogWant) begin
					mode_nxt = MODE_ANALOG;
				end else if (farWant) begin
					mode_nxt = MODE_FAR_REQ;
				end else if (dataWant) begin
					mode_nxt = MODE_DATA_LOOP;
				end
			end
			MODE_ANALOG: begin
				if (!analogWant) begin
					mode_nxt = MODE_IDLE;
				end
			end
			MODE_FAR_REQ: begin
				if (!farWant) begin
					mode_nxt = MODE_IDLE;
				end
			end
			MODE_DATA_LOOP: begin
				if (!dataWant) begin
					mode_nxt = MODE_IDLE;
				end
			end
			MODE_FAR_LOOPED: begin
				if (!farCmdS) begin
					mode_nxt = MODE_IDLE;
				end
			end
			default: begin
				mode_nxt = MODE_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_r <= MODE_IDLE;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// loop levels handed to the link domain, one-hot or none
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			analogLoop_r <= 1'b0;
			dataLoop_r   <= 1'b0;
			sendCmd_r    <= 1'b0;
		end else begin
			analogLoop_r <= (mode_r == MODE_ANALOG);
			dataLoop_r   <= (mode_r == MODE_DATA_LOOP) || (mode_r == MODE_FAR_LOOPED);
			sendCmd_r    <= (mode_r == MODE_FAR_REQ);
		end
	end

	// test indicator follows any loop mode
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			testModeIndicator <= 1'b0;
		end else begin
			testModeIndicator <= (mode_r != MODE_IDLE);
		end
	end

	// the line is not ours to send on while it carries looped data
	assign ready = (mode_r != MODE_FAR_LOOPED) && (mode_r != MODE_DATA_LOOP);

	// clear-to-send delay counter, restarts whenever rts or ready drops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctsCnt_r <= '0;
			ctsOut   <= 1'b0;
		end else begin
			if (!rtsS || !ready) begin
				ctsCnt_r <= '0;
			end else if (ctsCnt_r < ctsDelay_r) begin
				ctsCnt_r <= ctsCnt_r + 1'b1;
			end
			ctsOut <= rtsS && ready && (ctsCnt_r >= ctsDelay_r);
		end
	end

	// powered means out of reset
	assign dsrNxt = (mode_r != MODE_DATA_LOOP) && (mode_r != MODE_FAR_LOOPED);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dsrOut <= 1'b0;
			dcdOut <= 1'b0;
		end else begin
			dsrOut <= dsrNxt;
			dcdOut <= dsrNxt && !lossS;
		end
	end

	link_datapath u_link (
		.linkClk        (linkClk),
		.resetn         (resetn),
		.analogLoop     (analogLoop_r),
		.dataLoop       (dataLoop_r),
		.sendLoopCmd    (sendCmd_r),
		.dteTxData      (dteTxData),
		.lineRxData     (lineRxData),
		.lineLoopCmdIn  (lineLoopCmdIn),
		.lineTxData     (lineTxData),
		.lineLoopCmdOut (lineLoopCmdOut),
		.dteRxData      (dteRxData),
		.farCmdSeen     (farCmdLink),
		.txClkOut       (txClkOut),
		.rxClkOut       (rxClkOut)
	);

	// checks on the system-clock side
	default clocking cbSys @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_idle_far;
		mode_r == MODE_IDLE && !farCmdS && !analogWant && farWant;
	endsequence

	sequence s_idle_data;
		mode_r == MODE_IDLE && !farCmdS && !analogWant && !farWant && dataWant;
	endsequence

	sequence s_idle_analog;
		mode_r == MODE_IDLE && !farCmdS && analogWant;
	endsequence

	sequence s_rts_rise_long;
		$rose(rtsS) && ready && ctsDelay_r >= 16'h0003;
	endsequence

	a_far_cmd_sent: assert property (s_idle_far |=> mode_r == MODE_FAR_REQ ##1 sendCmd_r)
		else $error("far loop request did not raise the loop command");

	a_far_pin_cmd: assert property ((remoteReqS and s_idle_far) |=> ##1 sendCmd_r && testModeIndicator)
		else $error("remote loop pin did not start the far loop");

	a_far_cmd_holds: assert property (mode_r == MODE_FAR_REQ && farWant |=> sendCmd_r)
		else $error("loop command dropped while still requested");

	a_far_looped_test: assert property (mode_r == MODE_FAR_LOOPED |=> testModeIndicator && !dsrOut)
		else $error("far looped state without test indication");

	a_data_loop_on: assert property (s_idle_data |=> mode_r == MODE_DATA_LOOP ##1 dataLoop_r && !sendCmd_r)
		else $error("local data loop not entered");

	a_analog_entry: assert property (s_idle_analog |=> mode_r == MODE_ANALOG ##1 analogLoop_r)
		else $error("local analog loop not entered");

	a_analog_mark: assert property (mode_r == MODE_ANALOG |=> analogLoop_r && !dataLoop_r && !sendCmd_r)
		else $error("analog loop not isolated from the line");

	a_test_follows: assert property (##1 testModeIndicator == ($past(mode_r) != MODE_IDLE))
		else $error("test indicator disagrees with the loop mode");

	a_one_loop_only: assert property ($onehot0({analogLoop_r, dataLoop_r, sendCmd_r}))
		else $error("more than one loopback level active");

	a_cts_needs_rts: assert property ($rose(ctsOut) |-> $past(rtsS) && $past(ctsCnt_r) >= $past(ctsDelay_r))
		else $error("clear to send rose without request and delay");

	a_cts_not_early: assert property (s_rts_rise_long |-> !ctsOut [*3])
		else $error("clear to send came before its delay");

	a_dsr_by_mode: assert property ($past(resetn) |-> dsrOut == $past(dsrNxt))
		else $error("data set ready does not follow the loop mode");

	a_dcd_gated: assert property (dcdOut |-> dsrOut && !$past(lossS))
		else $error("carrier detect on during loss or without data set ready");

	a_bus_one_wait: assert property ((avsRead || avsWrite) && !ack_r |-> avsWaitRequest ##1 !avsWaitRequest)
		else $error("bus access did not finish after one wait cycle");
endmodule

// ---- testbench/far_side_model.sv ----
// far-side model: DTE serial source and far modem line driver
`timescale 1ns/1ps
module far_side_model (
	input  wire logic linkClk,              // line data-rate clock
	input  wire logic txClk,                // transmit clock from the modem
	input  wire logic txVal,                // next DTE bit
	input  wire logic rxVal,                // next line bit
	input  wire logic cmdVal,               // far modem asks for a loop
	output logic      dteTxData = 1'b1,     // DTE serial data
	output logic      lineRxData = 1'b1,    // line receive data
	output logic      lineLoopCmdIn = 1'b0  // loop command flag
);
	// the DTE changes its data only on a rising transmit clock edge
	always @(posedge txClk) begin
		dteTxData <= txVal;
	end
	// far modem line signals launched on the line clock
	always @(posedge linkClk) begin
		lineRxData <= rxVal;
		lineLoopCmdIn <= cmdVal;
	end
endmodule

// ---- testbench/modem_loopback_dte_control_tb.sv ----
// self-checking bench for the loopback and DTE control block
`timescale 1ns/1ps
module modem_loopback_dte_control_tb;
	import loop_ctl_pkg::*;
	logic        clk, resetn, linkClk, avsRead, avsWrite, rtsIn, loss;
	logic [3:0]  avsAddress;
	logic [31:0] avsWriteData, avsReadData, rd;
	logic [4:0]  reqs; // far button, data button, analog pin, far pin, far command
	logic        txVal, rxVal, avsWaitRequest, cts, dsr, dcd, tst;
	logic        dteTxData, lineRxData, cmdIn, lineTxData, cmdOut, dteRxData, txClk, rxClk;
	int          numErrors = 0;
	int          numChecks = 0;
	int          cyc = 0;

	// design under test with a short clear-to-send delay
	modem_loopback_dte_control #(.CTS_DELAY_RESET(4)) u_modem_loopback_dte_control (
		.clk(clk), .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(4'hF), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .farLoopButton(reqs[0]), .localDataLoopButton(reqs[1]),
		.localLoopRequest(reqs[2]), .remoteLoopRequest(reqs[3]), .rtsIn(rtsIn), .lineSignalLoss(loss),
		.ctsOut(cts), .dsrOut(dsr), .dcdOut(dcd), .testModeIndicator(tst), .linkClk(linkClk),
		.dteTxData(dteTxData), .lineRxData(lineRxData), .lineLoopCmdIn(cmdIn), .lineTxData(lineTxData),
		.lineLoopCmdOut(cmdOut), .dteRxData(dteRxData), .txClkOut(txClk), .rxClkOut(rxClk));

	// DTE and far modem
	far_side_model u_far_side_model (
		.linkClk(linkClk), .txClk(txClk), .txVal(txVal), .rxVal(rxVal), .cmdVal(reqs[4]),
		.dteTxData(dteTxData), .lineRxData(lineRxData), .lineLoopCmdIn(cmdIn));

	// system clock and an unrelated link clock
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	initial begin
		linkClk = 0;
		#3;
		forever #62.5 linkClk = ~linkClk;
	end

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			numErrors++;
			test_done();
		end
	end

	task test_done();
		$display("checks %0d mismatches %0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chkBit(input string n, input logic e, input logic s);
		numChecks++;
		if (s !== e) begin
			numErrors++;
			$display("Error %s expected %b seen %b", n, e, s);
		end
	endtask

	task chkWord(input string n, input logic [31:0] e, input logic [31:0] s);
		numChecks++;
		if (s !== e) begin
			numErrors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task busXfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avsAddress <= a;
		avsWriteData <= d;
		avsRead <= !w;
		avsWrite <= w;
		do @(posedge clk); while (avsWaitRequest !== 1'b0);
		rd = avsReadData;
		avsRead <= 0;
		avsWrite <= 0;
	endtask

	// enter a loop mode, try a competing request, check data routing, leave
	task loopCase(input logic [4:0] r, input logic [4:0] c, input logic [2:0] m, input logic d);
		@(posedge clk);
		reqs <= r;
		repeat (6) @(negedge linkClk); // far command crosses two domains before it counts
		@(posedge clk);
		reqs <= r | c;
		repeat (10) @(negedge linkClk);
		busXfer(0, ADDR_STATUS, 0);
		chkWord("mode", m, rd[2:0]);
		@(negedge clk);
		chkBit("test", 1, tst);
		chkBit("dsr", d, dsr);
		chkBit("dcd", d, dcd);
		chkBit("cmdOut", m == MODE_FAR_REQ, cmdOut);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk);
			txVal <= v[0];
			rxVal <= !v[0]; // opposite levels tell the two routes apart
			repeat (10) @(negedge linkClk);
			if (m == MODE_ANALOG) begin
				chkBit("lineTx", LINE_MARK, lineTxData);
				chkBit("dteRx", v[0], dteRxData);
			end else begin
				chkBit("lineTx", d ? v[0] : !v[0], lineTxData);
				chkBit("dteRx", !v[0], dteRxData);
			end
		end
		@(posedge clk);
		reqs <= 0;
		repeat (10) @(negedge linkClk);
		busXfer(0, ADDR_STATUS, 0);
		chkWord("idle", MODE_IDLE, rd[2:0]);
		@(negedge clk);
		chkBit("test", 0, tst);
		$display("loop case %0d done", m);
	endtask

	// main sequence
	initial begin
		resetn = 0;
		avsRead = 0;
		avsWrite = 0;
		avsAddress = 0;
		avsWriteData = 0;
		reqs = 0;
		rtsIn = 0;
		loss = 0;
		txVal = 1;
		rxVal = 1;
		repeat (12) @(posedge clk);
		repeat (2) @(posedge linkClk);
		@(posedge clk);
		resetn <= 1;
		repeat (3) @(negedge clk);
		chkBit("dsr", 1, dsr);
		chkBit("dcd", 1, dcd);
		chkBit("cts", 0, cts);
		chkBit("test", 0, tst);
		chkBit("txClk", linkClk, txClk);
		chkBit("rxClk", linkClk, rxClk);
		busXfer(0, ADDR_CTS_DELAY, 0);
		chkWord("ctsDelay", 4, rd);
		busXfer(1, ADDR_CTS_DELAY, 6);
		busXfer(0, ADDR_CTS_DELAY, 0);
		chkWord("ctsDelay", 6, rd);
		busXfer(1, 4'hC, 32'h5A);
		busXfer(0, 4'hC, 0);
		chkWord("unmapped", 0, rd);
		busXfer(1, ADDR_CTRL, 32'h4);
		busXfer(0, ADDR_STATUS, 0);
		chkWord("swAnalog", MODE_ANALOG, rd[2:0]);
		busXfer(0, ADDR_CTRL, 0);
		chkWord("ctrl", 32'h4, rd);
		busXfer(1, ADDR_CTRL, 0);
		busXfer(0, ADDR_STATUS, 0);
		chkWord("swIdle", MODE_IDLE, rd[2:0]);
		$display("register test done");
		@(posedge clk);
		rtsIn <= 1;
		repeat (5) @(negedge clk);
		chkBit("ctsEarly", 0, cts);
		for (int i = 0; i < 20 && cts !== 1'b1; i++) @(negedge clk);
		chkBit("cts", 1, cts);
		@(posedge clk);
		rtsIn <= 0;
		repeat (5) @(negedge clk);
		chkBit("ctsDrop", 0, cts);
		@(posedge clk);
		loss <= 1;
		repeat (5) @(negedge clk);
		chkBit("dcdLoss", 0, dcd);
		chkBit("dsrLoss", 1, dsr);
		@(posedge clk);
		loss <= 0;
		$display("handshake test done");
		loopCase(5'b00001, 5'b00100, MODE_FAR_REQ, 1);
		loopCase(5'b01000, 5'b00010, MODE_FAR_REQ, 1);
		loopCase(5'b00100, 5'b00001, MODE_ANALOG, 1);
		loopCase(5'b00010, 5'b00100, MODE_DATA_LOOP, 0);
		loopCase(5'b10000, 5'b00001, MODE_FAR_LOOPED, 0);
		test_done();
	end
endmodule
